// ==== rtl/wcm_pkg.sv ====
package wcm_pkg;
	localparam logic [6:0] HWC_ADDR = 7'h02;
	localparam logic [6:0] WDC_ADDR = 7'h03;
	localparam logic [6:0] CANC_ADDR = 7'h04;
	localparam int NUM_REGS = 3;
	localparam logic [15:0] HWC_POR = 16'h0000;
	localparam logic [15:0] HWC_SOFT_KEEP = 16'h0200;
	localparam logic [15:0] HWC_RESTART_KEEP = 16'h1240;
	localparam logic [15:0] HWC_RW_MASK = 16'h1e64;
	localparam int HWC_FAIL_SW_BIT = 5;
	localparam int HWC_STOP_UP_BIT = 2;
	localparam logic [15:0] WDC_POR = 16'h0014;
	localparam logic [15:0] WDC_RESTART = 16'h0004;
	localparam logic [15:0] WDC_RW_MASK = 16'h8077;
	localparam int WDC_BUS_WAKE_BIT = 4;
	localparam int WDC_CHECKSUM_BIT = 15;
	localparam int WDC_STOP_LO_BIT = 6;
	localparam int WDC_WINDOW_BIT = 5;
	localparam logic [15:0] CANC_POR = 16'h0020;
	localparam logic [15:0] CANC_RW_MASK = 16'h0007;
	localparam logic [2:0] CAN_NORMAL_LO = 3'h3;
	localparam logic [2:0] CAN_WAKE = 3'h1;
	localparam logic [2:0] CAN_FAILSAFE = 3'h1;
	localparam int CLK_MHZ = 100;
	localparam int WD_PERIOD_MS_0 = 10;
	localparam int WD_PERIOD_MS_1 = 20;
	localparam int WD_PERIOD_MS_2 = 50;
	localparam int WD_PERIOD_MS_3 = 100;
	localparam int WD_PERIOD_MS_4 = 200;
	localparam int WD_PERIOD_MS_5 = 500;
	localparam int WD_PERIOD_MS_6 = 1000;
	localparam int WD_PERIOD_MS_7 = 10000;
	typedef enum logic [3:0] {
		CAN_ST_OFF = 4'h1,
		CAN_ST_WAKE = 4'h2,
		CAN_ST_RECEIVE = 4'h4,
		CAN_ST_NORMAL = 4'h8
	} wcm_can_state_type;
endpackage : wcm_pkg

// ==== rtl/wcm_reg_word.sv ====
`timescale 1ns/1ps
`default_nettype none
// one 16-bit register with write mask and hardware override
module wcm_reg_word #(
	parameter logic [15:0] RESET_VAL = 16'h0000
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// software write
	input wire logic wr_en,
	input wire logic [15:0] wr_mask,
	input wire logic [15:0] wr_data,
	// hardware update, wins over software
	input wire logic hw_en,
	input wire logic [15:0] hw_data,
	// stored value
	output logic [15:0] value
);
	typedef struct packed {
		logic [15:0] word;
	} wcm_word_state_type;
	wcm_word_state_type st_reg;
	wcm_word_state_type st_next;
	always_comb begin
		st_next = st_reg;
		if (wr_en) begin
			st_next.word = wr_data & wr_mask;
		end
		if (hw_en) begin
			st_next.word = hw_data;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg.word <= RESET_VAL;
		end else begin
			st_reg <= st_next;
		end
	end
	assign value = st_reg.word;
endmodule : wcm_reg_word
`default_nettype wire

// ==== rtl/wcm_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module wcm_regs
	import wcm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register access port, word address, one-cycle strobes
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_addr_err,
	// device mode events, one-cycle pulses
	input wire logic soft_reset,
	input wire logic restart_entry,
	input wire logic [1:0] restart_can_cause,
	input wire logic stop_to_normal,
	input wire logic sleep_entry,
	input wire logic failsafe_entry,
	input wire logic system_error_flag,
	// failure sources
	input wire logic failure_flag,
	input wire logic fail_pin_is_output,
	// watchdog and transceiver controls
	output logic fail_output,
	output logic wdog_checksum_bit,
	output logic wdog_stop_disable,
	output logic wdog_window_select,
	output logic wdog_start_on_bus_wake,
	output logic [2:0] wdog_period_select,
	output logic [31:0] wdog_period_cycles,
	output wcm_can_state_type can_state,
	output logic selective_wake
);
	function automatic logic [31:0] period_cycles(input logic [2:0] sel);
		int ms;
		ms = WD_PERIOD_MS_0;
		unique case (sel)
			3'h0: ms = WD_PERIOD_MS_0;
			3'h1: ms = WD_PERIOD_MS_1;
			3'h2: ms = WD_PERIOD_MS_2;
			3'h3: ms = WD_PERIOD_MS_3;
			3'h4: ms = WD_PERIOD_MS_4;
			3'h5: ms = WD_PERIOD_MS_5;
			3'h6: ms = WD_PERIOD_MS_6;
			3'h7: ms = WD_PERIOD_MS_7;
		endcase
		return 32'(ms * CLK_MHZ * 1000);
	endfunction : period_cycles

	// one-hot register select for a word address, all zero when unmapped
	function automatic logic [NUM_REGS-1:0] addr_select(input logic [6:0] a);
		logic [NUM_REGS-1:0] sel;
		sel = '0;
		unique case (a)
			HWC_ADDR: sel[0] = 1'b1;
			WDC_ADDR: sel[1] = 1'b1;
			CANC_ADDR: sel[2] = 1'b1;
			default: sel = '0;
		endcase
		return sel;
	endfunction : addr_select

	// read view of the bank; reserved watchdog bits never come back set
	function automatic logic [15:0] read_word(input logic [NUM_REGS-1:0] sel,
		input logic [15:0] hwc, input logic [15:0] wdc, input logic [15:0] canc);
		logic [15:0] w;
		w = 16'h0000;
		if (sel[0]) begin
			w = hwc;
		end
		if (sel[1]) begin
			w = wdc & WDC_RW_MASK;
		end
		if (sel[2]) begin
			w = canc;
		end
		return w;
	endfunction : read_word

	// transceiver state from the low mode bits; code 100 lands on off
	function automatic wcm_can_state_type can_state_of(input logic [1:0] lo);
		wcm_can_state_type s;
		s = CAN_ST_OFF;
		unique case (lo)
			2'h0: s = CAN_ST_OFF;
			2'h1: s = CAN_ST_WAKE;
			2'h2: s = CAN_ST_RECEIVE;
			2'h3: s = CAN_ST_NORMAL;
		endcase
		return s;
	endfunction : can_state_of

	typedef struct packed {
		logic [15:0] rdata;
		logic addr_err;
		logic fail_out;
		logic fail_held;
		logic [31:0] period;
	} wcm_state_type;
	wcm_state_type st_reg;
	wcm_state_type st_next;

	logic [15:0] hwc_q;
	logic [15:0] wdc_q;
	logic [15:0] canc_q;
	logic hwc_hw;
	logic wdc_hw;
	logic canc_hw;
	logic [15:0] hwc_hw_data;
	logic [15:0] wdc_hw_data;
	logic [15:0] canc_hw_data;
	logic [NUM_REGS-1:0] wr_sel;
	logic [NUM_REGS-1:0] rd_sel;
	logic sw_fail_req;
	logic [15:0] wr_masks [NUM_REGS];
	logic [15:0] hw_dats [NUM_REGS];
	logic [NUM_REGS-1:0] hw_ens;
	logic [15:0] vals [NUM_REGS];
	localparam logic [15:0] RST_VALS [NUM_REGS] = '{HWC_POR, WDC_POR, CANC_POR};

	// write strobes, at most one set; an unmapped address selects nothing
	always_comb begin
		wr_sel = '0;
		if (reg_wr) begin
			wr_sel = addr_select(reg_addr);
		end
	end

	// hardware updates to the hardware control register
	always_comb begin
		hwc_hw = 1'b0;
		hwc_hw_data = hwc_q;
		if (stop_to_normal) begin
			hwc_hw = 1'b1;
			// a write in the same cycle keeps its other bits
			hwc_hw_data = (wr_sel[0] ? (reg_wdata & HWC_RW_MASK) : hwc_q);
			hwc_hw_data[HWC_STOP_UP_BIT] = 1'b0;
		end
		if (restart_entry) begin
			hwc_hw = 1'b1;
			hwc_hw_data = hwc_q & HWC_RESTART_KEEP;
		end
		// soft reset is checked last so it wins over restart
		if (soft_reset) begin
			hwc_hw = 1'b1;
			hwc_hw_data = hwc_q & HWC_SOFT_KEEP;
		end
	end

	// watchdog control hardware updates
	always_comb begin
		wdc_hw = 1'b0;
		wdc_hw_data = wdc_q;
		if (restart_entry) begin
			wdc_hw = 1'b1;
			wdc_hw_data = WDC_RESTART;
			wdc_hw_data[WDC_BUS_WAKE_BIT] = wdc_q[WDC_BUS_WAKE_BIT];
		end
		if (soft_reset) begin
			wdc_hw = 1'b1;
			wdc_hw_data = WDC_POR;
		end
	end

	// can mode hardware updates
	always_comb begin
		canc_hw = 1'b0;
		canc_hw_data = canc_q;
		// later events win: sleep, fail-safe, restart, then soft reset
		if (sleep_entry && !system_error_flag && can_state_of(canc_q[1:0]) == CAN_ST_NORMAL) begin
			canc_hw = 1'b1;
			canc_hw_data = {canc_q[15:3], canc_q[2], CAN_WAKE[1:0]};
		end
		if (failsafe_entry) begin
			canc_hw = 1'b1;
			canc_hw_data = {13'h0000, CAN_FAILSAFE} | (canc_q & 16'h00e0);
			canc_hw_data[2] = 1'b0;
		end
		if (restart_entry) begin
			canc_hw = 1'b1;
			canc_hw_data = {14'h0000, restart_can_cause};
		end
		if (soft_reset) begin
			canc_hw = 1'b1;
			canc_hw_data = CANC_POR;
		end
	end

	assign wr_masks[0] = HWC_RW_MASK;
	assign wr_masks[1] = WDC_RW_MASK;
	assign wr_masks[2] = CANC_RW_MASK;
	assign hw_ens = {canc_hw, wdc_hw, hwc_hw};
	assign hw_dats[0] = hwc_hw_data;
	assign hw_dats[1] = wdc_hw_data;
	assign hw_dats[2] = canc_hw_data;

	// one storage word per register; hardware updates beat a same-cycle write
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_regs
			wcm_reg_word #(
				.RESET_VAL(RST_VALS[gi])
			) u_word (
				.clk(clk),
				.arst_n(arst_n),
				.wr_en(wr_sel[gi]),
				.wr_mask(wr_masks[gi]),
				.wr_data(reg_wdata),
				.hw_en(hw_ens[gi]),
				.hw_data(hw_dats[gi]),
				.value(vals[gi])
			);
		end
	endgenerate
	assign hwc_q = vals[0];
	assign wdc_q = vals[1];
	assign canc_q = vals[2];
	assign rd_sel = addr_select(reg_addr);
	assign sw_fail_req = hwc_q[HWC_FAIL_SW_BIT] && fail_pin_is_output;

	always_comb begin
		st_next = st_reg;
		st_next.addr_err = 1'b0;
		if (reg_rd) begin
			st_next.rdata = read_word(rd_sel, hwc_q, wdc_q, canc_q);
			st_next.addr_err = rd_sel == '0;
		end
		if (reg_wr && wr_sel == '0) begin
			st_next.addr_err = 1'b1;
		end
		// failure term follows the status flag, so only clearing the flag drops it
		if (failure_flag) begin
			st_next.fail_held = 1'b1;
		end else begin
			st_next.fail_held = 1'b0;
		end
		// the held failure keeps the pin up whatever the software enable says
		st_next.fail_out = st_reg.fail_held || sw_fail_req;
		// count is registered so the period decode stays off the output path
		st_next.period = period_cycles(wdc_q[2:0]);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign can_state = can_state_of(canc_q[1:0]);

	assign selective_wake = canc_q[2] && canc_q[1:0] != 2'h0;
	assign reg_rdata = st_reg.rdata;
	assign reg_addr_err = st_reg.addr_err;
	assign fail_output = st_reg.fail_out;
	assign wdog_checksum_bit = wdc_q[WDC_CHECKSUM_BIT];
	assign wdog_stop_disable = wdc_q[WDC_STOP_LO_BIT] || hwc_q[HWC_STOP_UP_BIT];
	assign wdog_window_select = wdc_q[WDC_WINDOW_BIT];
	assign wdog_start_on_bus_wake = wdc_q[WDC_BUS_WAKE_BIT];
	assign wdog_period_select = wdc_q[2:0];
	assign wdog_period_cycles = st_reg.period;
endmodule : wcm_regs
`default_nettype wire

// ==== testbench/test_wcm_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_wcm_regs
	import wcm_pkg::*;
;
	logic clk = 1'b0, arst_n = 1'b0, reg_wr, reg_rd, reg_addr_err, fail_output, sw;
	logic wdog_checksum_bit, wdog_stop_disable, wdog_window_select, wdog_start_on_bus_wake;
	logic [6:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [2:0] wdog_period_select;
	logic [31:0] wdog_period_cycles;
	wcm_can_state_type can_state;
	logic [4:0] ev = 5'h00;
	logic serr = 1'b0, fflag = 1'b0, rd_d = 1'b0, bad_d = 1'b0;
	logic [1:0] cause = 2'h2;
	logic [15:0] exp_q[$];
	int n_fail = 0, check_count = 0, seed = 32'ha9bff03a;
	int ms[8] = '{10, 20, 50, 100, 200, 500, 1000, 10000};
	wcm_host host_u (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
	wcm_regs dut_u (.clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.reg_addr_err, .soft_reset(ev[0]), .restart_entry(ev[1]), .restart_can_cause(cause),
		.stop_to_normal(ev[2]), .sleep_entry(ev[3]), .failsafe_entry(ev[4]),
		.system_error_flag(serr), .failure_flag(fflag), .fail_pin_is_output(1'b1), .fail_output,
		.wdog_checksum_bit, .wdog_stop_disable, .wdog_window_select, .wdog_start_on_bus_wake,
		.wdog_period_select, .wdog_period_cycles, .can_state, .selective_wake(sw));
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic rdx(input logic [6:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host_u.xfer(1'b0, a, 16'h0000);
	endtask : rdx
	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		host_u.xfer(1'b1, a, v);
	endtask : wr
	task automatic pulse(input int i);
		@(posedge clk) #1;
		ev[i] = 1'b1;
		@(posedge clk) #1;
		ev = 5'h00;
	endtask : pulse
	// read data and address errors land one edge after the access
	always @(posedge clk) begin
		if (rd_d) chk(reg_rdata, exp_q.pop_front());
		if (bad_d) chk(reg_addr_err, 1);
		rd_d <= reg_rd && reg_addr inside {HWC_ADDR, WDC_ADDR, CANC_ADDR};
		bad_d <= (reg_rd | reg_wr) && !(reg_addr inside {HWC_ADDR, WDC_ADDR, CANC_ADDR});
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 arst_n = 1'b1;
		rdx(HWC_ADDR, 16'h0000);
		rdx(WDC_ADDR, 16'h0014);
		rdx(CANC_ADDR, 16'h0020);
		for (int k = 0; k < 8; k++) begin
			d = (16'($random(seed)) & 16'hfff8) | 16'(k);
			wr(WDC_ADDR, d);
			rdx(WDC_ADDR, d & 16'h8077);
			chk(wdog_checksum_bit, d[15]);
			chk(wdog_stop_disable, d[6]);
			chk(wdog_window_select, d[5]);
			chk(wdog_start_on_bus_wake, d[4]);
			chk(wdog_period_cycles, ms[k] * 100000);
			chk(wdog_period_select, k);
			wr(CANC_ADDR, 16'hfff8 | 16'(k));
			rdx(CANC_ADDR, 16'(k));
			chk(can_state, 4'h1 << k[1:0]);
			chk(sw, k inside {5, 6, 7});
		end
		wr(WDC_ADDR, 16'h00e7);
		wr(HWC_ADDR, 16'hffff);
		rdx(HWC_ADDR, 16'h1e64);
		chk(fail_output, 1);
		cause = 2'($random(seed));
		pulse(1);
		rdx(HWC_ADDR, 16'h1240);
		rdx(WDC_ADDR, 16'h0004);
		rdx(CANC_ADDR, {14'h0000, cause});
		chk(fail_output, 0);
		wr(HWC_ADDR, 16'hffff);
		pulse(0);
		rdx(HWC_ADDR, 16'h0200);
		rdx(WDC_ADDR, 16'h0014);
		wr(HWC_ADDR, 16'h0004);
		chk(wdog_stop_disable, 1);
		pulse(2);
		rdx(HWC_ADDR, 16'h0000);
		chk(wdog_stop_disable, 0);
		fflag = 1'b1;
		wr(HWC_ADDR, 16'h0020);
		wr(HWC_ADDR, 16'h0000);
		chk(fail_output, 1);
		fflag = 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(fail_output, 0);
		serr = 1'b1;
		wr(CANC_ADDR, 16'h0003);
		pulse(3);
		rdx(CANC_ADDR, 16'h0003);
		serr = 1'b0;
		wr(CANC_ADDR, 16'h0007);
		pulse(3);
		rdx(CANC_ADDR, 16'h0005);
		pulse(4);
		rdx(CANC_ADDR, 16'h0001);
		host_u.xfer(1'b0, 7'h7f, 16'h0000);
		repeat (3) @(posedge clk);
		chk(exp_q.size(), 0);
		tally_and_finish();
	end
endmodule : test_wcm_regs
`default_nettype wire

// ==== testbench/wcm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module wcm_host (
	input wire logic clk,
	output logic [6:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_wdata
);
	initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 25'h0;
	task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d);
		@(posedge clk) #1;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, wr, !wr};
		@(posedge clk) #1;
		// idle lines do not keep the last value
		{reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
	endtask : xfer
endmodule : wcm_host
`default_nettype wire

// ==== testbench/wcm_regs_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module wcm_regs_props
	import wcm_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic soft_reset,
	input wire logic restart_entry,
	input wire logic sleep_entry,
	input wire logic failsafe_entry,
	input wire logic system_error_flag,
	input wire logic failure_flag,
	input wire logic fail_output,
	input wire logic wdog_checksum_bit,
	input wire logic wdog_stop_disable,
	input wire logic wdog_window_select,
	input wire logic wdog_start_on_bus_wake,
	input wire logic [2:0] wdog_period_select,
	input wire wcm_can_state_type can_state,
	input wire logic selective_wake
);
	logic evt;
	assign evt = soft_reset | restart_entry | failsafe_entry;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	a_wd_res: assert property (
		reg_rd && reg_addr == WDC_ADDR |=> (reg_rdata & ~WDC_RW_MASK) == 16'h0000)
		else $error("reserved bits set");
	a_fail_held: assert property (
		failure_flag ##1 failure_flag |=> fail_output) else $error("fail output dropped");
	a_fail_restart: assert property (
		restart_entry && !failure_flag |-> ##2 !fail_output) else $error("fail output kept");
	a_wd_restart: assert property (
		restart_entry && !soft_reset |=> wdog_period_select == 3'h4 && !wdog_window_select
		&& !wdog_checksum_bit && $stable(wdog_start_on_bus_wake)) else $error("bad restart");
	a_wd_soft: assert property (
		soft_reset |=> wdog_period_select == 3'h4 && wdog_start_on_bus_wake
		&& !wdog_window_select && !wdog_stop_disable) else $error("bad soft reset");
	a_can_fs: assert property (
		failsafe_entry && !soft_reset && !restart_entry
		|=> can_state == CAN_ST_WAKE && !selective_wake) else $error("bad failsafe");
	a_can_sleep: assert property (
		sleep_entry && !system_error_flag && can_state == CAN_ST_NORMAL && !evt
		|=> can_state == CAN_ST_WAKE && $stable(selective_wake)) else $error("bad sleep");
	a_can_code: assert property (
		reg_wr && reg_addr == CANC_ADDR && !evt && !sleep_entry
		|=> can_state == (4'h1 << $past(reg_wdata[1:0]))
		&& selective_wake == ($past(reg_wdata[2]) && $past(reg_wdata[1:0]) != 2'h0))
		else $error("bad can mode");
endmodule : wcm_regs_props
bind wcm_regs wcm_regs_props props_u (.clk, .arst_n, .reg_addr, .reg_wr, .reg_rd,
	.reg_wdata, .reg_rdata, .soft_reset, .restart_entry, .sleep_entry, .failsafe_entry,
	.system_error_flag, .failure_flag, .fail_output, .wdog_checksum_bit, .wdog_stop_disable,
	.wdog_window_select, .wdog_start_on_bus_wake, .wdog_period_select, .can_state,
	.selective_wake);
`default_nettype wire
